// ==== src/fsps_pkg.sv ====
// Package for the flash self-program sequencer: register map, control
// fields, command patterns, arming windows and programming times.
// Assumes a 40 MHz system clock and a 32-bit APB register bus.
package fsps_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS  = 8'h00;  // prog_mem_ctrl_status
  localparam logic [7:0] PTR_OFS   = 8'h04;  // pointer_high_byte:pointer_low_byte
  localparam logic [7:0] DATA_OFS  = 8'h08;  // data_word_pair
  localparam logic [7:0] INSTR_OFS = 8'h0C;  // Issue instruction / load result
  localparam logic [7:0] STAT_OFS  = 8'h10;  // Sequencer status

  // ----------------------------------------------------------------
  // Control field positions and command patterns
  // ----------------------------------------------------------------
  localparam int STORE_EN_B   = 0;
  localparam int PAGE_ERASE_B = 1;
  localparam int PAGE_WRITE_B = 2;
  localparam int CLEAR_BUF_B  = 4;
  localparam int INSTR_STORE_B = 0;
  localparam int INSTR_LOAD_B  = 1;
  localparam logic [7:0] PAT_FILL  = 8'h01;
  localparam logic [7:0] PAT_ERASE = 8'h03;
  localparam logic [7:0] PAT_WRITE = 8'h05;
  localparam logic [7:0] PAT_FUSE  = 8'h09;
  localparam logic [7:0] PAT_SIG   = 8'h21;
  localparam logic [7:0] CTRL_WMASK = 8'h2F;  // Bits kept; clear bit is a strobe
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Windows, special addresses, reset values
  // ----------------------------------------------------------------
  localparam logic [2:0]  STORE_WIN = 3'h4;
  localparam logic [2:0]  LOAD_WIN  = 3'h3;
  localparam logic [15:0] ADR_FUSE_LOW = 16'h0000;
  localparam logic [15:0] ADR_LOCK     = 16'h0001;
  localparam logic [15:0] ADR_FUSE_EXT = 16'h0002;
  localparam logic [15:0] ADR_FUSE_HI  = 16'h0003;
  localparam logic [15:0] ERASED_WORD  = 16'hFFFF;

  // ----------------------------------------------------------------
  // Programming time
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int PROG_MIN_NS   = 3700000;
  localparam int PROG_MAX_NS   = 4500000;
  localparam int PROG_MIN_CYC  = (PROG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROG_MAX_CYC  = PROG_MAX_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    FSPS_IDLE   = 2'b00,
    FSPS_ERASE  = 2'b01,
    FSPS_STREAM = 2'b10,
    FSPS_WAIT   = 2'b11
  } fsps_state_t;

  typedef enum logic [2:0] {
    FSPS_CMD_NONE  = 3'b000,
    FSPS_CMD_FILL  = 3'b001,
    FSPS_CMD_ERASE = 3'b010,
    FSPS_CMD_WRITE = 3'b011,
    FSPS_CMD_FUSE  = 3'b100,
    FSPS_CMD_SIG   = 3'b101
  } fsps_cmd_t;

endpackage : fsps_pkg

// ==== src/fsps_top.sv ====
// Flash self-program sequencer: page buffer, erase/write sequencing and
// fuse, lock and signature read-back, steered over APB.
// Assumes fuse inputs, EEPROM busy flag and flash read data are on CLOCK.
//
// Notes on behaviour
// - Store instruction is ignored unless the self-program fuse reads 0.
// - Each store fills one 16-bit buffer word, before or after erase.
// - Buffer words may be loaded in any order.
// - Pattern 03h plus store within four cycles erases the pointed page.
// - Core is halted for the whole page erase.
// - Pattern 01h plus store puts the data pair at the word index.
// - Buffer clears after page write, on clear-bit write and on reset.
// - An EEPROM write during buffer filling discards the loaded words.
// - Pattern 05h plus store within four cycles writes the pointed page.
// - Core is halted for the whole page write.
// - Pointer low bits pick the word, high bits pick the page.
// - Load reads flash bytewise; pointer bit 0 selects the byte.
// - EEPROM write in progress blocks programming and fuse or lock reads.
// - Fuses, lock bits and signature are readable; programmed bits read 0.
// - Erase and write bits clear at completion or after four idle cycles.
// - Fuse/lock read by load within three cycles; command bits then clear.
// - Signature read by load within three cycles returns the indexed entry.
// - Each erase or write lasts between 3.7 ms and 4.5 ms.
`timescale 1ns/100ps

module fsps_top
  import fsps_pkg::*;
#(
  parameter int          PAGE_WORDS  = 32,
  parameter int          PROG_CYCLES = PROG_MIN_CYC,
  parameter logic [31:0] SIG_TABLE   = 32'h5A3C_1E0F  // Arbitrary value
) (
  input  wire logic        CLOCK,
  input  wire logic        RESET_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        SELF_PROGRAM_FUSE,
  input  wire logic        EEPROM_WRITE_BUSY_FLAG,
  input  wire logic [7:0]  FUSE_LOW,
  input  wire logic [7:0]  FUSE_HIGH,
  input  wire logic [7:0]  FUSE_EXT,
  input  wire logic [7:0]  LOCK_BITS,
  output logic [15:0]      FLASH_READ_ADDR,
  input  wire logic [7:0]  FLASH_READ_DATA,
  output logic             FLASH_ERASE,
  output logic             FLASH_PROG_WE,
  output logic [14:0]      FLASH_PROG_ADDR,
  output logic [15:0]      FLASH_PROG_DATA,
  output logic             CPU_HALT
);

  localparam int WB = $clog2(PAGE_WORDS);

  initial begin
    if (PAGE_WORDS < 2 || PAGE_WORDS > 256 || (1 << WB) != PAGE_WORDS)
      $error("PAGE_WORDS must be a power of two from 2 to 256");
    if (PROG_CYCLES < 2 || PROG_CYCLES > 262143)
      $error("PROG_CYCLES out of range");
  end

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0]      ctrl_reg;
  logic [15:0]     ptr_reg;
  logic [15:0]     data_reg;
  logic [7:0]      load_reg;
  logic [2:0]      arm_reg;
  logic [17:0]     timer_reg;
  logic [WB-1:0]   idx_reg;
  fsps_state_t     state_reg;
  logic [15:0]     buf_mem [PAGE_WORDS];
  logic [PAGE_WORDS-1:0] loaded_reg;

  // Bus decode
  logic wr_acc;
  logic ctrl_wr;
  logic instr_wr;
  logic store_go;
  logic load_go;
  logic store_ok;
  logic load_ok;
  logic buf_clear;
  logic prog_done;
  logic [WB-1:0] widx;
  fsps_cmd_t cmd;

  // Command pattern decode
  function automatic fsps_cmd_t decode(input logic [7:0] c);
    unique case (c)
      PAT_FILL:  decode = FSPS_CMD_FILL;
      PAT_ERASE: decode = FSPS_CMD_ERASE;
      PAT_WRITE: decode = FSPS_CMD_WRITE;
      PAT_FUSE:  decode = FSPS_CMD_FUSE;
      PAT_SIG:   decode = FSPS_CMD_SIG;
      default:   decode = FSPS_CMD_NONE;
    endcase
  endfunction : decode

  // Register address check
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == CTRL_OFS) || (a == PTR_OFS) || (a == DATA_OFS) ||
             (a == INSTR_OFS) || (a == STAT_OFS);
  endfunction : mapped

  // Access phase strobes and instruction validity
  assign wr_acc    = PSEL && PENABLE && PWRITE && mapped(PADDR);
  assign ctrl_wr   = wr_acc && (PADDR == CTRL_OFS) && (state_reg == FSPS_IDLE);
  assign instr_wr  = wr_acc && (PADDR == INSTR_OFS) && (state_reg == FSPS_IDLE);
  assign store_go  = instr_wr && PWDATA[INSTR_STORE_B];
  assign load_go   = instr_wr && PWDATA[INSTR_LOAD_B] && !PWDATA[INSTR_STORE_B];
  assign cmd       = decode(ctrl_reg);
  assign store_ok  = store_go && !SELF_PROGRAM_FUSE && (arm_reg != 3'h0)
                     && !EEPROM_WRITE_BUSY_FLAG;
  assign load_ok   = load_go && (arm_reg > (STORE_WIN - LOAD_WIN))
                     && !EEPROM_WRITE_BUSY_FLAG;
  assign widx      = ptr_reg[WB:1];
  assign prog_done = (state_reg == FSPS_WAIT) && (timer_reg == 18'h00001);
  // Of the two completions only a finished page write empties the buffer; a finished erase keeps
  // words filled before it so that they can still be written afterwards
  assign buf_clear = (prog_done && ctrl_reg[PAGE_WRITE_B]) ||
                     (ctrl_wr && PWDATA[CLEAR_BUF_B]) ||
                     (EEPROM_WRITE_BUSY_FLAG && (loaded_reg != '0));

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped(PADDR);

  // Read data captured in the setup phase, shown in the access phase
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      PRDATA <= 32'h0000_0000;
    end else if (PSEL && !PENABLE) begin
      unique case (PADDR)
        CTRL_OFS:  PRDATA <= {24'h000000, ctrl_reg};
        PTR_OFS:   PRDATA <= {16'h0000, ptr_reg};
        DATA_OFS:  PRDATA <= {16'h0000, data_reg};
        INSTR_OFS: PRDATA <= {24'h000000, load_reg};
        STAT_OFS:  PRDATA <= {24'h000000, (loaded_reg != '0), arm_reg,
                              state_reg, CPU_HALT, EEPROM_WRITE_BUSY_FLAG};
        default:   PRDATA <= 32'h0000_0000;
      endcase
    end
  end

  // Pointer and data pair registers
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      ptr_reg  <= 16'h0000;
      data_reg <= 16'h0000;
    end else if (wr_acc && state_reg == FSPS_IDLE) begin
      if (PADDR == PTR_OFS)
        ptr_reg <= PWDATA[15:0];
      if (PADDR == DATA_OFS)
        data_reg <= PWDATA[15:0];
    end
  end

  // ----------------------------------------------------------------
  // Control register and arming window
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl_reg <= CTRL_RESET;
      arm_reg  <= 3'h0;
    end else if (ctrl_wr) begin
      ctrl_reg <= PWDATA[7:0] & CTRL_WMASK;
      arm_reg  <= PWDATA[STORE_EN_B] ? STORE_WIN : 3'h0;
    end else if (prog_done) begin
      ctrl_reg <= CTRL_RESET;
      arm_reg  <= 3'h0;
    end else if (store_ok && (cmd == FSPS_CMD_ERASE || cmd == FSPS_CMD_WRITE)) begin
      arm_reg  <= 3'h0;                                       // Bits held until done
    end else if (store_ok || load_ok) begin
      ctrl_reg <= CTRL_RESET;
      arm_reg  <= 3'h0;
    end else if (arm_reg == 3'h1) begin
      ctrl_reg <= CTRL_RESET;
      arm_reg  <= 3'h0;
    end else if (arm_reg != 3'h0) begin
      arm_reg  <= arm_reg - 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // Temporary page buffer
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      loaded_reg <= '0;
      for (int i = 0; i < PAGE_WORDS; i++)
        buf_mem[i] <= ERASED_WORD;
    end else if (buf_clear) begin
      loaded_reg <= '0;
      for (int i = 0; i < PAGE_WORDS; i++)
        buf_mem[i] <= ERASED_WORD;
    end else if (store_ok && cmd == FSPS_CMD_FILL) begin
      buf_mem[widx]    <= data_reg;
      loaded_reg[widx] <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Erase and write sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_reg <= FSPS_IDLE;
      timer_reg <= 18'h00000;
      idx_reg   <= '0;
    end else begin
      unique case (state_reg)
        FSPS_IDLE: begin
          idx_reg <= '0;
          if (store_ok && cmd == FSPS_CMD_ERASE) begin
            state_reg <= FSPS_ERASE;
            timer_reg <= 18'(PROG_CYCLES);
          end else if (store_ok && cmd == FSPS_CMD_WRITE) begin
            state_reg <= FSPS_STREAM;
          end
        end
        FSPS_ERASE: begin
          state_reg <= FSPS_WAIT;
        end
        FSPS_STREAM: begin
          idx_reg <= idx_reg + 1'b1;
          if (idx_reg == WB'(PAGE_WORDS - 1)) begin
            state_reg <= FSPS_WAIT;
            timer_reg <= 18'(PROG_CYCLES);
          end
        end
        FSPS_WAIT: begin
          timer_reg <= timer_reg - 18'h00001;
          if (timer_reg == 18'h00001)
            state_reg <= FSPS_IDLE;
        end
      endcase
    end
  end

  // Flash programming strobes, page taken from the pointer
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      FLASH_ERASE     <= 1'b0;
      FLASH_PROG_WE   <= 1'b0;
      FLASH_PROG_ADDR <= 15'h0000;
      FLASH_PROG_DATA <= 16'h0000;
    end else begin
      FLASH_ERASE   <= store_ok && cmd == FSPS_CMD_ERASE;
      FLASH_PROG_WE <= state_reg == FSPS_STREAM;
      if (state_reg == FSPS_IDLE && store_ok)
        FLASH_PROG_ADDR <= {ptr_reg[15:WB+1], {WB{1'b0}}};
      else if (state_reg == FSPS_STREAM)
        FLASH_PROG_ADDR <= {FLASH_PROG_ADDR[14:WB], idx_reg};
      FLASH_PROG_DATA <= buf_mem[idx_reg];
    end
  end

  // Core halt while any erase or write runs
  assign CPU_HALT = state_reg != FSPS_IDLE;

  // ----------------------------------------------------------------
  // Load path: flash bytes, fuses, lock bits, signature
  // ----------------------------------------------------------------
  assign FLASH_READ_ADDR = ptr_reg;

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      load_reg <= 8'h00;
    end else if (load_ok && cmd == FSPS_CMD_FUSE) begin
      unique case (ptr_reg)
        ADR_FUSE_LOW: load_reg <= FUSE_LOW;
        ADR_LOCK:     load_reg <= LOCK_BITS;
        ADR_FUSE_EXT: load_reg <= FUSE_EXT;
        ADR_FUSE_HI:  load_reg <= FUSE_HIGH;
        default:      load_reg <= 8'hFF;
      endcase
    end else if (load_ok && cmd == FSPS_CMD_SIG) begin
      load_reg <= SIG_TABLE[{ptr_reg[1:0], 3'b000} +: 8];
    end else if (load_go) begin
      load_reg <= FLASH_READ_DATA;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);

  property p_fuse_off;
    (store_go && SELF_PROGRAM_FUSE) |=> state_reg == FSPS_IDLE && !FLASH_ERASE;
  endproperty
  a_fuse_off: assert property (p_fuse_off) else $error("store ran with fuse off");

  property p_erase_start;
    (store_ok && cmd == FSPS_CMD_ERASE)
      |=> FLASH_ERASE && state_reg == FSPS_ERASE ##1 timer_reg == 18'(PROG_CYCLES);
  endproperty
  a_erase_start: assert property (p_erase_start) else $error("erase did not start");

  property p_halt;
    (FLASH_ERASE || FLASH_PROG_WE) |-> CPU_HALT;
  endproperty
  a_halt: assert property (p_halt) else $error("core not halted");

  property p_fill;
    (store_ok && cmd == FSPS_CMD_FILL && !buf_clear)
      |=> buf_mem[$past(widx)] == $past(data_reg) && loaded_reg[$past(widx)];
  endproperty
  a_fill: assert property (p_fill) else $error("buffer word not loaded");

  property p_clear_write;
    (prog_done && ctrl_reg[PAGE_WRITE_B])
      |=> loaded_reg == '0 && state_reg == FSPS_IDLE && ctrl_reg == CTRL_RESET;
  endproperty
  a_clear_write: assert property (p_clear_write) else $error("write end incomplete");

  property p_ee_discard;
    (EEPROM_WRITE_BUSY_FLAG && loaded_reg != '0) |=> loaded_reg == '0;
  endproperty
  a_ee_discard: assert property (p_ee_discard) else $error("buffer kept during eeprom");

  property p_ee_block;
    (EEPROM_WRITE_BUSY_FLAG && instr_wr) |=> state_reg == FSPS_IDLE && !FLASH_ERASE;
  endproperty
  a_ee_block: assert property (p_ee_block) else $error("programming during eeprom");

  property p_expire;
    (arm_reg == 3'h1 && !ctrl_wr && !store_ok && !load_ok) |=> ctrl_reg == CTRL_RESET;
  endproperty
  a_expire: assert property (p_expire) else $error("command bits not cleared");

  property p_lock_read;
    (load_ok && cmd == FSPS_CMD_FUSE && ptr_reg == ADR_LOCK)
      |=> load_reg == $past(LOCK_BITS) && ctrl_reg == CTRL_RESET;
  endproperty
  a_lock_read: assert property (p_lock_read) else $error("lock read wrong");

  property p_write_len;
    (state_reg == FSPS_STREAM && idx_reg == WB'(PAGE_WORDS - 1))
      |=> state_reg == FSPS_WAIT && timer_reg == 18'(PROG_CYCLES);
  endproperty
  a_write_len: assert property (p_write_len) else $error("write time not loaded");

endmodule : fsps_top

// ==== test/fsps_flash_model.sv ====
// Flash array model standing on the far side of the sequencer's flash port.
// Assumes the sequencer's clock; erase sets a whole page to FFFF.
`timescale 1ns/100ps

module fsps_flash_model #(
  parameter int PAGE_WORDS = 4
) (
  input  wire logic        clock,
  input  wire logic [15:0] flash_read_addr,
  output logic      [7:0]  flash_read_data,
  input  wire logic        flash_erase,
  input  wire logic        flash_prog_we,
  input  wire logic [14:0] flash_prog_addr,
  input  wire logic [15:0] flash_prog_data
);
  logic [15:0] mem [0:32767];
  int          base;

  // ------------------------------------------------------------------
  // Array contents
  // ------------------------------------------------------------------
  // Start from a non-erased pattern so that a missed erase shows up
  initial begin
    for (int i = 0; i < 32768; i++) begin
      mem[i] = 16'(i) ^ 16'h5AA5;
    end
  end

  // Erase a page; programming can only clear bits, like real cells
  always @(posedge clock) begin
    base = (int'(flash_prog_addr) / PAGE_WORDS) * PAGE_WORDS;
    if (flash_erase) begin
      for (int w = 0; w < PAGE_WORDS; w++) begin
        mem[base + w] <= 16'hFFFF;
      end
    end
    if (flash_prog_we) begin
      mem[flash_prog_addr] <= mem[flash_prog_addr] & flash_prog_data;
    end
  end

  // Byte read; address bit 0 picks the high byte
  assign flash_read_data = flash_read_addr[0] ? mem[flash_read_addr[15:1]][15:8]
                                              : mem[flash_read_addr[15:1]][7:0];
endmodule : fsps_flash_model

// ==== test/fsps_top_bench.sv ====
// Self-checking bench for the flash self-program sequencer, driven over APB.
// Assumes the flash model as far side and a shortened programming time.
`timescale 1ns/100ps

`define CHK(act, exp) begin total_checks++; if ((act) !== (exp)) begin fails++; \
  $display("Error %0t: got %h expected %h", $time, act, exp); end end

module fsps_top_bench import fsps_pkg::*;;
  localparam int          PW   = 4;
  localparam int          PC   = 20;
  localparam logic [31:0] SIG  = 32'hC3D2_1B0A;  // Arbitrary value
  localparam logic [15:0] BASE = 16'h0128;       // Page 25h, word 0

  logic        clock, reset_n, psel, penable, pwrite, pready, pslverr;
  logic        spf, ee_busy, f_erase, f_we, cpu_halt;
  logic [7:0]  paddr, fuse_low, fuse_high, fuse_ext, lock_bits, fr_data;
  logic [31:0] pwdata, prdata, seed, e;
  logic [15:0] fr_addr, f_data;
  logic [14:0] f_addr;
  logic [30:0] p;
  logic [15:0] dat [4];
  logic [7:0]  fx [5];
  logic [31:0] exp_q [$];
  logic [30:0] prog_q [$];
  int          fails, total_checks;

  fsps_top #(.PAGE_WORDS(PW), .PROG_CYCLES(PC), .SIG_TABLE(SIG)) dut (
    .CLOCK(clock), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .SELF_PROGRAM_FUSE(spf), .EEPROM_WRITE_BUSY_FLAG(ee_busy), .FUSE_LOW(fuse_low),
    .FUSE_HIGH(fuse_high), .FUSE_EXT(fuse_ext), .LOCK_BITS(lock_bits),
    .FLASH_READ_ADDR(fr_addr), .FLASH_READ_DATA(fr_data), .FLASH_ERASE(f_erase),
    .FLASH_PROG_WE(f_we), .FLASH_PROG_ADDR(f_addr), .FLASH_PROG_DATA(f_data),
    .CPU_HALT(cpu_halt));

  fsps_flash_model #(.PAGE_WORDS(PW)) flash (
    .clock(clock), .flash_read_addr(fr_addr), .flash_read_data(fr_data),
    .flash_erase(f_erase), .flash_prog_we(f_we), .flash_prog_addr(f_addr),
    .flash_prog_data(f_data));

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // One APB transfer; entered just after a rising edge, bus left held
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int k;
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 50);
  endtask : apb

  task automatic idle(input int c);
    psel    <= 1'b0;
    penable <= 1'b0;
    repeat (c) @(posedge clock);
  endtask : idle

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    exp_q.push_back(x);
    apb(a, 1'b0, 32'h0000_0000);
  endtask : rd

  // Status read once any arming window has run out
  task automatic st(input logic [31:0] x);
    idle(6);
    rd(STAT_OFS, x);
  endtask : st

  task automatic cmd(input logic [15:0] ptr, input logic [7:0] pat, input logic [31:0] ins);
    apb(PTR_OFS, 1'b1, {16'h0000, ptr});
    apb(CTRL_OFS, 1'b1, {24'h00_0000, pat});
    apb(INSTR_OFS, 1'b1, ins);
  endtask : cmd

  task automatic ld(input logic [15:0] ptr, input logic [7:0] pat, input logic [7:0] x);
    cmd(ptr, pat, 32'h0000_0002);
    rd(INSTR_OFS, {24'h00_0000, x});
  endtask : ld

  // Loads all buffer words out of order, once each since the last clear
  task automatic fill_all();
    int w;
    for (int k = 0; k < PW; k++) begin
      w = (k * 3 + 2) % PW;
      apb(DATA_OFS, 1'b1, {16'h0000, dat[w]});
      cmd(BASE | 16'(w * 2), PAT_FILL, 32'h0000_0001);
    end
  endtask : fill_all

  // Counts halted cycles of one erase or write
  task automatic wait_op(input int lo, input int hi);
    int h;
    h = 0;
    idle(0);
    for (int i = 0; i < 400; i++) begin
      @(posedge clock);
      if (cpu_halt === 1'b1) h++;
      else if (h > 0) break;
    end
    `CHK(h >= lo && h <= hi, 1'b1)
  endtask : wait_op

  task automatic close_out();
    `CHK(exp_q.size() + prog_q.size(), 0)
    if (fails == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out

  // ------------------------------------------------------------------
  // Clock, result monitor, watchdog
  // ------------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // Read data and programmed words against the oldest notes
  always @(posedge clock) begin
    if (psel && penable) begin
      `CHK({pready, pslverr}, {1'b1, !(paddr inside {CTRL_OFS, PTR_OFS, DATA_OFS, INSTR_OFS, STAT_OFS})})
    end
    if (psel && penable && !pwrite) begin
      e = exp_q.pop_front();
      `CHK(prdata, e)
    end
    if (f_we === 1'b1) begin
      p = prog_q.pop_front();
      `CHK({f_addr, f_data}, p)
    end
  end

  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    close_out();
  end

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  initial begin
    seed = 32'hE659;
    fails = 0;
    total_checks = 0;
    {reset_n, psel, penable, pwrite, spf, ee_busy} = 6'b000010;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    {fuse_low, fuse_high, fuse_ext, lock_bits} = rnd();
    for (int k = 0; k < PW; k++) dat[k] = 16'(rnd());
    fx = '{fuse_low, lock_bits, fuse_ext, fuse_high, 8'hFF};
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    rd(CTRL_OFS, 32'h0);
    rd(STAT_OFS, 32'h0);
    rd(8'h14, 32'h0);
    // Store refused while the self-program fuse is unprogrammed
    apb(DATA_OFS, 1'b1, 32'h0000_1234);
    cmd(BASE, PAT_FILL, 32'h0000_0001);
    st(32'h0);
    spf <= 1'b0;
    fill_all();
    st(32'h80);
    apb(CTRL_OFS, 1'b1, 32'h0000_0010);
    st(32'h0);
    fill_all();
    ee_busy <= 1'b1;
    idle(2);
    ee_busy <= 1'b0;
    st(32'h0);
    fill_all();
    // Erase armed but the window lapses; a late store does nothing
    apb(PTR_OFS, 1'b1, {16'h0000, BASE});
    apb(CTRL_OFS, 1'b1, {24'h00_0000, PAT_ERASE});
    idle(6);
    rd(CTRL_OFS, 32'h0);
    apb(INSTR_OFS, 1'b1, 32'h0000_0001);
    st(32'h80);
    // Erase with word bits set still clears the whole page only
    cmd(BASE | 16'h0006, PAT_ERASE, 32'h0000_0001);
    wait_op(PC, PC + 4);
    rd(CTRL_OFS, 32'h0);
    ld(BASE, 8'h00, 8'hFF);
    ld(BASE + 16'h0008, 8'h00, 8'h3D);
    for (int w = 0; w < PW; w++) prog_q.push_back({15'(BASE >> 1) + 15'(w), dat[w]});
    cmd(BASE, PAT_WRITE, 32'h0000_0001);
    wait_op(PC + PW, PC + PW + 6);
    st(32'h0);
    for (int b = 0; b < PW * 2; b++) ld(BASE | 16'(b), 8'h00, 8'(dat[b / 2] >> (8 * (b % 2))));
    // Write again after an erase: buffer was emptied by the last write
    cmd(BASE, PAT_ERASE, 32'h0000_0001);
    wait_op(PC, PC + 4);
    for (int w = 0; w < PW; w++) prog_q.push_back({15'(BASE >> 1) + 15'(w), 16'hFFFF});
    cmd(BASE, PAT_WRITE, 32'h0000_0001);
    wait_op(PC + PW, PC + PW + 6);
    // EEPROM write in progress blocks the fill
    ee_busy <= 1'b1;
    apb(DATA_OFS, 1'b1, 32'h0000_0000);
    cmd(BASE | 16'h0002, PAT_FILL, 32'h0000_0001);
    st(32'h1);
    ee_busy <= 1'b0;
    for (int k = 0; k < 5; k++) ld(16'(k), PAT_FUSE, fx[k]);
    rd(CTRL_OFS, 32'h0);
    for (int k = 0; k < 4; k++) ld(16'(k), PAT_SIG, SIG[k * 8 +: 8]);
    // Fuse read armed but expired: load reads flash again
    apb(PTR_OFS, 1'b1, 32'h0000_0000);
    apb(CTRL_OFS, 1'b1, {24'h00_0000, PAT_FUSE});
    idle(5);
    apb(INSTR_OFS, 1'b1, 32'h0000_0002);
    rd(INSTR_OFS, 32'h0000_00A5);
    idle(2);
    close_out();
  end
endmodule : fsps_top_bench
